//--- common/ifd_pkg.sv
// shared constants and types for the instruction format decoder
`default_nettype none
package ifd_pkg;
	localparam int          MAX_WORDS      = 7;
	localparam int          MAX_EXT        = MAX_WORDS - 1;
	localparam logic [15:0] OP_NOP         = 16'h4E71;
	localparam logic [15:0] OP_RTS         = 16'h4E75;
	localparam logic [15:0] OP_CTRLMV      = 16'h4E7A;
	localparam logic [15:0] OP_CTRLMV_MASK = 16'hFFFE;
	localparam logic [15:0] OP_HALT        = 16'hF800;
	localparam logic [15:0] HALT_EXT       = 16'h01C0;
	localparam logic [9:0]  OP_INTP_TOP    = 10'h3E0;
	localparam logic [5:0]  OP_MULL_TOP    = 6'h30;
	localparam logic [5:0]  OP_DIVL_TOP    = 6'h31;
	localparam logic [11:0] CR_SRCFC       = 12'h000;
	localparam logic [11:0] CR_DSTFC       = 12'h001;
	localparam logic [11:0] CR_VECB        = 12'h801;
	localparam logic [1:0]  SEL_NONE       = 2'h0;
	localparam logic [1:0]  SEL_VECB       = 2'h1;
	localparam logic [1:0]  SEL_SRCFC      = 2'h2;
	localparam logic [1:0]  SEL_DSTFC      = 2'h3;
	localparam logic [1:0]  SZ_BYTE        = 2'h0;
	localparam logic [1:0]  SZ_WORD        = 2'h1;
	localparam logic [1:0]  SZ_LONG        = 2'h2;
	localparam int          COND_LSB       = 8;
	localparam int          EXT_SIZE_LSB   = 6;
	localparam int          EXT_ROUND_BIT  = 10;
	localparam int          EXT_WIDE_BIT   = 10;
	localparam int          EXT_UNS_BIT    = 11;
	localparam int          EXT_REGA_LSB   = 12;
	localparam int          HALT_MASK_LSB  = 8;
	localparam logic [1:0]  LOC_REG        = 2'h0;
	localparam logic [1:0]  LOC_EA         = 2'h1;
	localparam logic [1:0]  LOC_IMPLICIT   = 2'h2;
	typedef enum logic [4:0] {
		ST_OP   = 5'h01,
		ST_EXT  = 5'h02,
		ST_DEC  = 5'h04,
		ST_OUT  = 5'h08,
		ST_HALT = 5'h10
	} ifd_state_e;
	typedef enum logic [3:0] {
		CL_TRAP = 4'h0, CL_MISC = 4'h1, CL_BCC = 4'h2, CL_DECBR = 4'h3,
		CL_CTRAP = 4'h4, CL_SCC = 4'h5, CL_QUICK = 4'h6, CL_MOVEQ = 4'h7,
		CL_MOVE = 4'h8, CL_CTRLMV = 4'h9, CL_MULL = 4'hA, CL_DIVL = 4'hB,
		CL_HALT = 4'hC, CL_INTP = 4'hD
	} ifd_class_e;
endpackage
`default_nettype wire

//--- hw/ifd_interp.sv
// table interpolation arithmetic between two bounding entries
`default_nettype none
module ifd_interp (
	input  wire logic        clock,
	input  wire logic        rstn,
	input  wire logic        start,
	input  wire logic [31:0] entry_lo,
	input  wire logic [31:0] entry_hi,
	input  wire logic [7:0]  frac,
	input  wire logic [1:0]  size,
	input  wire logic        is_unsigned,
	input  wire logic        round,
	output logic             done,
	output logic [31:0]      result,
	output logic [7:0]       frac_out
);
	// widen an entry by operand size and signedness
	function automatic logic signed [33:0] widen(input logic [31:0] v, input logic [1:0] sz,
		input logic sg);
		logic signed [33:0] r;
		r = 34'sh0;
		if (sz == ifd_pkg::SZ_BYTE)
			r = {{26{sg & v[7]}}, v[7:0]};
		else if (sz == ifd_pkg::SZ_WORD)
			r = {{18{sg & v[15]}}, v[15:0]};
		else
			r = {{2{sg & v[31]}}, v};
		return r;
	endfunction

	// lo + (hi - lo) * frac / 256, optional half-step bias for rounding
	wire logic signed [33:0] lo_w     = widen(entry_lo, size, ~is_unsigned);
	wire logic signed [33:0] hi_w     = widen(entry_hi, size, ~is_unsigned);
	wire logic signed [42:0] diff_w   = 43'(hi_w) - 43'(lo_w);
	wire logic signed [42:0] prod_w   = diff_w * 43'($signed({1'b0, frac}));
	wire logic signed [42:0] bias_w   = round ? 43'sh80 : 43'sh0;
	wire logic signed [42:0] scaled_w = (prod_w + bias_w) >>> 8;
	wire logic signed [42:0] sum_w    = scaled_w + 43'(lo_w);

	// one-cycle result register; the fraction only matters unrounded
	always_ff @(posedge clock or negedge rstn)
	begin
		if (!rstn)
		begin
			done     <= 1'b0;
			result   <= 32'h0;
			frac_out <= 8'h0;
		end
		else
		begin
			done     <= start;
			result   <= start ? sum_w[31:0] : result;
			frac_out <= start ? (round ? 8'h0 : prod_w[7:0]) : frac_out;
		end
	end

	AST_TBL_DONE: assert property (@(posedge clock) disable iff (!rstn) start |=> done)
		else $error("interpolation did not complete in one cycle");
endmodule // ifd_interp
`default_nettype wire

//--- hw/ifd_decoder.sv
// operation word and extension word decoder with low power halt
`default_nettype none
// Contract
// - every instruction is at least one word
// - up to seven words per instruction
// - length and operation come from operation word; halt and interpolation share one, told apart by the first extension word
// - specifier, source, destination extension order
// - operand by register, address mode, or implicit
// - unimplemented opcode raises trap, nothing executes
// - halt instruction enters low power standby
// - standby ends on enough interrupt or reset
// - interpolate between two bounding table entries
// - byte, word and long table sizes
// - rounded, or unrounded with fraction, not long
// - conditional instructions pick one of 16 tests
// - control move reaches vector base, function codes
// - long multiply gives high and low registers
// - long divide names remainder and quotient registers
module ifd_decoder (
	input  wire logic         clock,
	input  wire logic         rstn,
	input  wire logic         fetch_valid,
	input  wire logic [15:0]  fetch_word,
	output logic              fetch_ready,
	input  wire logic         exec_ready,
	output logic              dec_valid,
	output logic              dec_trap,
	output logic [3:0]        dec_class,
	output logic [2:0]        dec_len,
	output logic [2:0]        dec_spec_n,
	output logic [2:0]        dec_src_n,
	output logic [2:0]        dec_dst_n,
	output logic [15:0]       dec_op,
	output logic [95:0]       dec_ext,
	output logic [1:0]        dec_loc_kind,
	output logic [3:0]        dec_cond,
	output logic [1:0]        dec_size,
	output logic [1:0]        dec_ctrl_sel,
	output logic [2:0]        dec_reg_a,
	output logic [2:0]        dec_reg_b,
	output logic              dec_wide,
	output logic              dec_round,
	output logic              dec_unsigned,
	input  wire logic [2:0]   irq_level_pin,
	output logic              halted,
	input  wire logic         tbl_start,
	input  wire logic [31:0]  tbl_entry_lo,
	input  wire logic [31:0]  tbl_entry_hi,
	input  wire logic [7:0]   tbl_frac,
	output logic              tbl_done,
	output logic [31:0]       tbl_result,
	output logic [7:0]        tbl_frac_out
);
	// extension words an effective address field adds
	function automatic logic [2:0] ea_ext(input logic [2:0] m, input logic [2:0] r,
		input logic [1:0] sz);
		if (m == 3'h5 || m == 3'h6)
			return 3'h1;
		else if (m != 3'h7)
			return 3'h0;
		else if (r == 3'h1)
			return 3'h2;
		else if (r == 3'h4)
			return (sz == ifd_pkg::SZ_LONG) ? 3'h2 : 3'h1;
		else if (r <= 3'h3)
			return 3'h1;
		return 3'h0;
	endfunction

	function automatic logic ea_bad(input logic [2:0] m, input logic [2:0] r);
		return (m == 3'h7) && (r > 3'h4);
	endfunction

	ifd_pkg::ifd_state_e state_ff, nxt_state;
	ifd_pkg::ifd_class_e cls_ff, d_cls;
	logic [15:0] op_ff;
	logic [15:0] ext_ff [ifd_pkg::MAX_EXT];
	logic [2:0]  cnt_ff, spec_ff, src_ff, dst_ff, words_ff;
	logic [2:0]  d_spec, d_src, d_dst;
	logic [1:0]  sz_ff, d_sz;
	logic        d_bad;
	logic [2:0]  mask_ff;
	logic [2:0]  irq_meta_ff, irq_ff;

	// classify the operation word alone; length is fixed here, except that a confirmed halt adds one specifier word later
	always_comb
	begin
		d_cls  = ifd_pkg::CL_TRAP;
		d_spec = 3'h0;
		d_src  = 3'h0;
		d_dst  = 3'h0;
		d_sz   = ifd_pkg::SZ_WORD;
		d_bad  = ea_bad(fetch_word[5:3], fetch_word[2:0]);
		case (fetch_word[15:12])
			4'h1, 4'h2, 4'h3:
			begin
				d_cls = ifd_pkg::CL_MOVE;
				d_sz  = (fetch_word[13:12] == 2'h1) ? ifd_pkg::SZ_BYTE :
					(fetch_word[13:12] == 2'h3) ? ifd_pkg::SZ_WORD : ifd_pkg::SZ_LONG;
				d_src = ea_ext(fetch_word[5:3], fetch_word[2:0], d_sz);
				d_dst = ea_ext(fetch_word[8:6], fetch_word[11:9], d_sz);
				d_bad = d_bad || (fetch_word[8:6] == 3'h7 && fetch_word[11:9] > 3'h1);
			end
			4'h4:
			begin
				if (fetch_word == ifd_pkg::OP_NOP || fetch_word == ifd_pkg::OP_RTS)
					d_cls = ifd_pkg::CL_MISC;
				else if ((fetch_word & ifd_pkg::OP_CTRLMV_MASK) == ifd_pkg::OP_CTRLMV)
				begin
					d_cls  = ifd_pkg::CL_CTRLMV;
					d_spec = 3'h1;
				end
				else if (fetch_word[11:6] == ifd_pkg::OP_MULL_TOP ||
					fetch_word[11:6] == ifd_pkg::OP_DIVL_TOP)
				begin
					d_cls  = fetch_word[6] ? ifd_pkg::CL_DIVL : ifd_pkg::CL_MULL;
					d_spec = 3'h1;
					d_sz   = ifd_pkg::SZ_LONG;
					d_src  = ea_ext(fetch_word[5:3], fetch_word[2:0], ifd_pkg::SZ_LONG);
				end
			end
			4'h5:
			begin
				if (fetch_word[7:6] != 2'h3)
				begin
					d_cls = ifd_pkg::CL_QUICK;
					d_sz  = fetch_word[7:6];
					d_src = ea_ext(fetch_word[5:3], fetch_word[2:0], d_sz);
				end
				else if (fetch_word[5:3] == 3'h1)
				begin
					d_cls = ifd_pkg::CL_DECBR;
					d_src = 3'h1;
				end
				else if (fetch_word[5:3] == 3'h7 && fetch_word[2:0] >= 3'h2)
				begin
					d_cls = ifd_pkg::CL_CTRAP;
					d_src = (fetch_word[2:0] == 3'h4) ? 3'h0 : 3'(fetch_word[2:0] - 3'h1);
					d_bad = fetch_word[2:0] > 3'h4;
				end
				else
				begin
					d_cls = ifd_pkg::CL_SCC;
					d_src = ea_ext(fetch_word[5:3], fetch_word[2:0], ifd_pkg::SZ_BYTE);
				end
			end
			4'h6:
			begin
				d_cls = ifd_pkg::CL_BCC;
				d_src = (fetch_word[7:0] == 8'h00) ? 3'h1 :
					(fetch_word[7:0] == 8'hFF) ? 3'h2 : 3'h0;
				d_bad = 1'b0;
			end
			4'h7:
			begin
				d_cls = fetch_word[8] ? ifd_pkg::CL_TRAP : ifd_pkg::CL_MOVEQ;
				d_bad = 1'b0;
			end
			4'hF:
			begin
				if (fetch_word[15:6] == ifd_pkg::OP_INTP_TOP)
				begin
					// the halt word shares its code with register-form interpolation
					d_cls  = (fetch_word == ifd_pkg::OP_HALT) ? ifd_pkg::CL_HALT : ifd_pkg::CL_INTP;
					d_spec = 3'h1;
					d_src  = ea_ext(fetch_word[5:3], fetch_word[2:0], ifd_pkg::SZ_LONG);
				end
			end
			default: d_cls = ifd_pkg::CL_TRAP;
		endcase
	end

	wire logic       take_w      = fetch_valid & fetch_ready;
	wire logic [3:0] d_need_w    = 4'(d_spec) + 4'(d_src) + 4'(d_dst);
	wire logic       d_trap_w    = (d_cls == ifd_pkg::CL_TRAP) || d_bad ||
		(d_need_w > 4'(ifd_pkg::MAX_EXT));
	wire logic       halt_first_w = (cls_ff == ifd_pkg::CL_HALT) && (cnt_ff == 3'h0);
	wire logic       halt_conf_w  = halt_first_w && (fetch_word == ifd_pkg::HALT_EXT);
	wire logic [2:0] spec_now_w   = halt_conf_w ? 3'h2 : spec_ff;
	wire logic [3:0] need_w       = 4'(spec_now_w) + 4'(src_ff) + 4'(dst_ff);
	wire logic       ext_last_w   = (4'(cnt_ff) + 4'h1) >= need_w;
	wire logic       wake_w       = (irq_ff != 3'h0) && (irq_ff >= mask_ff);

	// sequencing: operation word, extension words, decode, hand over
	always_comb
	begin
		nxt_state = state_ff;
		case (state_ff)
			ifd_pkg::ST_OP:
				if (take_w)
					nxt_state = (d_trap_w || d_need_w == 4'h0) ? ifd_pkg::ST_DEC : ifd_pkg::ST_EXT;
			ifd_pkg::ST_EXT:
				if (take_w && ext_last_w)
					nxt_state = ifd_pkg::ST_DEC;
			ifd_pkg::ST_DEC:
				nxt_state = ifd_pkg::ST_OUT;
			ifd_pkg::ST_OUT:
				if (exec_ready)
					nxt_state = (cls_ff == ifd_pkg::CL_HALT && !dec_trap) ?
						ifd_pkg::ST_HALT : ifd_pkg::ST_OP;
			ifd_pkg::ST_HALT:
				if (wake_w)
					nxt_state = ifd_pkg::ST_OP;
			default: nxt_state = ifd_pkg::ST_OP;
		endcase
	end

	assign fetch_ready = (state_ff == ifd_pkg::ST_OP) || (state_ff == ifd_pkg::ST_EXT);
	assign dec_valid   = (state_ff == ifd_pkg::ST_OUT);
	assign halted      = (state_ff == ifd_pkg::ST_HALT);

	always_ff @(posedge clock or negedge rstn)
	begin
		if (!rstn)
			state_ff <= ifd_pkg::ST_OP;
		else
			state_ff <= nxt_state;
	end

	// capture operation word and its length split
	always_ff @(posedge clock or negedge rstn)
	begin
		if (!rstn)
		begin
			op_ff <= 16'h0;
			cls_ff <= ifd_pkg::CL_TRAP;
			{spec_ff, src_ff, dst_ff, cnt_ff, words_ff} <= 15'h0;
			sz_ff <= ifd_pkg::SZ_WORD;
		end
		else if (take_w && state_ff == ifd_pkg::ST_OP)
		begin
			op_ff <= fetch_word;
			cls_ff <= d_trap_w ? ifd_pkg::CL_TRAP : d_cls;
			spec_ff <= d_trap_w ? 3'h0 : d_spec;
			src_ff <= d_trap_w ? 3'h0 : d_src;
			dst_ff <= d_trap_w ? 3'h0 : d_dst;
			sz_ff <= d_sz;
			cnt_ff <= 3'h0;
			words_ff <= 3'h1;
		end
		else if (take_w)
		begin
			if (halt_first_w && !halt_conf_w)
				cls_ff <= ifd_pkg::CL_INTP;
			spec_ff <= spec_now_w;
			cnt_ff <= 3'(cnt_ff + 3'h1);
			words_ff <= 3'(words_ff + 3'h1);
		end
	end

	// extension word store, filled in arrival order
	always_ff @(posedge clock or negedge rstn)
	begin
		if (!rstn)
		begin
			for (int i = 0; i < ifd_pkg::MAX_EXT; i++)
				ext_ff[i] <= 16'h0;
		end
		else if (take_w && state_ff == ifd_pkg::ST_EXT)
			ext_ff[cnt_ff] <= fetch_word;
	end

	genvar g;
	generate
		for (g = 0; g < ifd_pkg::MAX_EXT; g++)
		begin : g_ext
			assign dec_ext[g*16 +: 16] = ext_ff[g];
		end
	endgenerate

	// field extraction from stored words
	wire logic [11:0] cr_w      = ext_ff[0][11:0];
	wire logic [1:0]  sel_w     = (cr_w == ifd_pkg::CR_VECB) ? ifd_pkg::SEL_VECB :
		(cr_w == ifd_pkg::CR_SRCFC) ? ifd_pkg::SEL_SRCFC :
		(cr_w == ifd_pkg::CR_DSTFC) ? ifd_pkg::SEL_DSTFC : ifd_pkg::SEL_NONE;
	wire logic        is_tbl_w  = (cls_ff == ifd_pkg::CL_INTP);
	wire logic [1:0]  tsz_w     = ext_ff[0][ifd_pkg::EXT_SIZE_LSB +: 2];
	wire logic        trnd_w    = ~ext_ff[0][ifd_pkg::EXT_ROUND_BIT];
	wire logic        tbad_w    = is_tbl_w && ((tsz_w == 2'h3) ||
		(!trnd_w && tsz_w == ifd_pkg::SZ_LONG));
	wire logic        trap_w    = (cls_ff == ifd_pkg::CL_TRAP) || tbad_w ||
		(cls_ff == ifd_pkg::CL_CTRLMV && sel_w == ifd_pkg::SEL_NONE);
	wire logic        ext_reg_w = (cls_ff == ifd_pkg::CL_MULL) || (cls_ff == ifd_pkg::CL_DIVL)
		|| is_tbl_w;
	wire logic [1:0]  loc_w     = (cls_ff == ifd_pkg::CL_MOVEQ || cls_ff == ifd_pkg::CL_DECBR) ?
		ifd_pkg::LOC_REG : (cls_ff == ifd_pkg::CL_MISC || cls_ff == ifd_pkg::CL_BCC ||
		cls_ff == ifd_pkg::CL_HALT) ? ifd_pkg::LOC_IMPLICIT : ifd_pkg::LOC_EA;

	// decode results registered so the execution stage sees flops
	always_ff @(posedge clock or negedge rstn)
	begin
		if (!rstn)
		begin
			{dec_trap, dec_wide, dec_round, dec_unsigned} <= 4'h0;
			{dec_class, dec_cond} <= 8'h0;
			{dec_len, dec_spec_n, dec_src_n, dec_dst_n} <= 12'h0;
			dec_op <= 16'h0;
			{dec_loc_kind, dec_size, dec_ctrl_sel} <= 6'h0;
			{dec_reg_a, dec_reg_b} <= 6'h0;
		end
		else if (state_ff == ifd_pkg::ST_DEC)
		begin
			dec_trap <= trap_w;
			dec_class <= cls_ff;
			dec_len <= words_ff;
			dec_spec_n <= spec_ff;
			dec_src_n <= src_ff;
			dec_dst_n <= dst_ff;
			dec_op <= op_ff;
			dec_loc_kind <= loc_w;
			dec_cond <= op_ff[ifd_pkg::COND_LSB +: 4];
			dec_size <= is_tbl_w ? tsz_w : sz_ff;
			dec_ctrl_sel <= (cls_ff == ifd_pkg::CL_CTRLMV) ? sel_w : ifd_pkg::SEL_NONE;
			dec_reg_a <= ext_reg_w ? ext_ff[0][ifd_pkg::EXT_REGA_LSB +: 3] : op_ff[11:9];
			dec_reg_b <= ext_reg_w ? ext_ff[0][2:0] : op_ff[2:0];
			dec_wide <= ext_ff[0][ifd_pkg::EXT_WIDE_BIT] && !is_tbl_w;
			dec_round <= trnd_w;
			dec_unsigned <= ext_ff[0][ifd_pkg::EXT_UNS_BIT];
		end
	end

	// interrupt level from pins, synchronised; mask from the halt immediate
	always_ff @(posedge clock or negedge rstn)
	begin
		if (!rstn)
		begin
			irq_meta_ff <= 3'h0;
			irq_ff <= 3'h0;
			mask_ff <= 3'h7;
		end
		else
		begin
			irq_meta_ff <= irq_level_pin;
			irq_ff <= irq_meta_ff;
			if (state_ff == ifd_pkg::ST_OUT && cls_ff == ifd_pkg::CL_HALT)
				mask_ff <= ext_ff[1][ifd_pkg::HALT_MASK_LSB +: 3];
		end
	end

	ifd_interp u_interp (
		.clock       (clock),
		.rstn        (rstn),
		.start       (tbl_start),
		.entry_lo    (tbl_entry_lo),
		.entry_hi    (tbl_entry_hi),
		.frac        (tbl_frac),
		.size        (dec_size),
		.is_unsigned (dec_unsigned),
		.round       (dec_round),
		.done        (tbl_done),
		.result      (tbl_result),
		.frac_out    (tbl_frac_out)
	);

	default clocking cb @(posedge clock); endclocking
	default disable iff (!rstn);

	sequence halt_wake_s;
		halted && wake_w;
	endsequence

	AST_LEN_MIN: assert property (dec_valid |-> dec_len >= 3'h1)
		else $error("instruction length below one word");
	AST_LEN_MAX: assert property (dec_valid |-> dec_len <= 3'h7)
		else $error("instruction length above seven words");
	AST_LEN_SUM: assert property (dec_valid && !dec_trap |->
		4'(dec_len) == 4'(dec_spec_n) + 4'(dec_src_n) + 4'(dec_dst_n) + 4'h1)
		else $error("extension groups do not add to the length");
	AST_ALL_WORDS: assert property (dec_valid |-> dec_len == words_ff)
		else $error("handed over before all words arrived");
	AST_LEN_FROM_OP: assert property (take_w && state_ff == ifd_pkg::ST_OP &&
		fetch_word == ifd_pkg::OP_NOP |-> ##2 dec_valid && dec_len == 3'h1)
		else $error("single word operation not handed over at once");
	AST_TRAP_ALINE: assert property (take_w && state_ff == ifd_pkg::ST_OP &&
		fetch_word[15:12] == 4'hA |-> ##2 dec_valid && dec_trap)
		else $error("unimplemented opcode did not trap");
	AST_HALT_STAY: assert property (halted && !wake_w |=> halted && !fetch_ready)
		else $error("standby left without a wake event");
	AST_HALT_WAKE: assert property (halt_wake_s |=> !halted ##1 fetch_ready)
		else $error("standby not left on a qualifying interrupt");
	AST_COND: assert property (dec_valid && (dec_class == ifd_pkg::CL_BCC ||
		dec_class == ifd_pkg::CL_DECBR) |-> dec_cond == dec_op[11:8])
		else $error("condition test not taken from the operation word");
	AST_CTRL: assert property (dec_valid && dec_class == ifd_pkg::CL_CTRLMV && !dec_trap
		|-> dec_ctrl_sel != ifd_pkg::SEL_NONE)
		else $error("control register move without a valid register");
	AST_MULDIV: assert property (dec_valid && (dec_class == ifd_pkg::CL_MULL ||
		dec_class == ifd_pkg::CL_DIVL) |-> dec_reg_a == dec_ext[14:12] &&
		dec_reg_b == dec_ext[2:0])
		else $error("long multiply or divide register pair mismatch");
	AST_UNRND: assert property (dec_valid && dec_class == ifd_pkg::CL_INTP && !dec_round &&
		dec_size == ifd_pkg::SZ_LONG |-> dec_trap)
		else $error("unrounded long interpolation accepted");
	AST_LOC: assert property (dec_valid && dec_class == ifd_pkg::CL_MOVEQ
		|-> dec_loc_kind == ifd_pkg::LOC_REG)
		else $error("quick move operand not a register field");
endmodule // ifd_decoder
`default_nettype wire

//--- verification/ifd_fetch_model.sv
// fetch path and execution stage model facing the decoder
`default_nettype none
module ifd_fetch_model (
	input  wire logic        clock,
	input  wire logic        rstn,
	input  wire logic        fetch_ready,
	input  wire logic        dec_valid,
	output logic             fetch_valid,
	output logic [15:0]      fetch_word,
	output logic             exec_ready
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [15:0] q[$];
	int          gap;
	int          hold;
	logic        taken;
	logic        acc;
	initial
	begin
		fetch_valid = 1'b0;
		fetch_word  = 16'hA5A5;
		exec_ready  = 1'b0;
		gap         = 0;
		hold        = 0;
	end
	// words leave in pushed order; idle word toggles so it never looks held
	always
	begin
		@(posedge clock);
		taken = fetch_valid && fetch_ready;
		acc   = dec_valid && exec_ready;
		#1;
		if (taken)
		begin
			void'(q.pop_front());
			hold = gap;
		end
		else if (hold > 0)
			hold--;
		if (rstn && q.size() > 0 && hold == 0)
		begin
			fetch_valid = 1'b1;
			fetch_word  = q[0];
		end
		else
		begin
			fetch_valid = 1'b0;
			fetch_word  = ~fetch_word;
		end
		// execution accepts one cycle after the offer is seen
		exec_ready = !acc && dec_valid;
	end
endmodule // ifd_fetch_model
`default_nettype wire

//--- verification/tb_top.sv
// self-checking bench for the instruction format decoder
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	logic clock = 1'b0;
	logic rstn = 1'b0;
	logic fetch_valid, fetch_ready, exec_ready, dec_valid, dec_trap, halted;
	logic [15:0] fetch_word, dec_op;
	logic [3:0] dec_class, dec_cond;
	logic [2:0] dec_len, dec_spec_n, dec_src_n, dec_dst_n, dec_reg_a, dec_reg_b;
	logic [95:0] dec_ext;
	logic [1:0] dec_loc_kind, dec_size, dec_ctrl_sel;
	logic dec_wide, dec_round, dec_unsigned, tbl_start, tbl_done;
	logic [2:0] irq_level_pin = 3'h0;
	logic [31:0] tbl_entry_lo, tbl_entry_hi, tbl_result;
	logic [7:0] tbl_frac, tbl_frac_out;
	int failures = 0;
	int check_count = 0;
	int waited;
	always #4 clock = ~clock;
	ifd_fetch_model u_fetch (.clock(clock), .rstn(rstn), .fetch_ready(fetch_ready),
		.dec_valid(dec_valid), .fetch_valid(fetch_valid), .fetch_word(fetch_word),
		.exec_ready(exec_ready));
	ifd_decoder DUT (.clock(clock), .rstn(rstn), .fetch_valid(fetch_valid),
		.fetch_word(fetch_word), .fetch_ready(fetch_ready), .exec_ready(exec_ready),
		.dec_valid(dec_valid), .dec_trap(dec_trap), .dec_class(dec_class),
		.dec_len(dec_len), .dec_spec_n(dec_spec_n), .dec_src_n(dec_src_n),
		.dec_dst_n(dec_dst_n), .dec_op(dec_op), .dec_ext(dec_ext),
		.dec_loc_kind(dec_loc_kind), .dec_cond(dec_cond), .dec_size(dec_size),
		.dec_ctrl_sel(dec_ctrl_sel), .dec_reg_a(dec_reg_a), .dec_reg_b(dec_reg_b),
		.dec_wide(dec_wide), .dec_round(dec_round), .dec_unsigned(dec_unsigned),
		.irq_level_pin(irq_level_pin), .halted(halted), .tbl_start(tbl_start),
		.tbl_entry_lo(tbl_entry_lo), .tbl_entry_hi(tbl_entry_hi), .tbl_frac(tbl_frac),
		.tbl_done(tbl_done), .tbl_result(tbl_result), .tbl_frac_out(tbl_frac_out));
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", check_count, failures);
		if (failures == 0 && check_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp)
		begin
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
			failures++;
		end
	endtask
	// push whole instruction, then wait boundedly for the offer
	task automatic issue(input int n, input logic [15:0] w0, w1 = 0, w2 = 0);
		int i;
		for (i = 0; i < 20 && dec_valid !== 1'b0; i++)
			@(posedge clock) #1;
		u_fetch.q.push_back(w0);
		if (n > 1)
			u_fetch.q.push_back(w1);
		if (n > 2)
			u_fetch.q.push_back(w2);
		for (waited = 0; waited < 60 && dec_valid !== 1'b1; waited++)
			@(posedge clock) #1;
		if (dec_valid !== 1'b1)
		begin
			failures++;
			print_verdict();
		end
	endtask
	task automatic t_format();
		issue(1, ifd_pkg::OP_NOP);
		chk(dec_len, 3'h1);
		chk(dec_trap, 1'b0);
		u_fetch.gap = 5;
		issue(2, 16'h3228, 16'h0010);
		u_fetch.gap = 0;
		chk(waited > 6, 1'b1);
		chk({dec_len, dec_spec_n, dec_src_n, dec_dst_n}, 12'h408);
		chk(dec_loc_kind, ifd_pkg::LOC_EA);
		chk(dec_ext[15:0], 16'h0010);
		issue(1, 16'h7205);
		chk(dec_loc_kind, ifd_pkg::LOC_REG);
		issue(1, ifd_pkg::OP_RTS);
		chk(dec_loc_kind, ifd_pkg::LOC_IMPLICIT);
		issue(1, 16'hA000);
		chk({dec_trap, dec_len}, 4'h9);
	endtask
	task automatic t_cond();
		int c;
		for (c = 0; c < 16; c++)
		begin
			issue(1, 16'h6002 | (16'(c) << 8));
			chk({dec_cond, dec_len}, {4'(c), 3'h1});
			issue(2, 16'h50C8 | (16'(c) << 8), 16'h0004);
			chk({dec_cond, dec_len}, {4'(c), 3'h2});
			issue(1, 16'h50FC | (16'(c) << 8));
			chk({dec_cond, dec_len, dec_trap}, {4'(c), 3'h1, 1'b0});
		end
	endtask
	task automatic t_ctrl();
		issue(2, ifd_pkg::OP_CTRLMV, 16'h1801);
		chk(dec_ctrl_sel, ifd_pkg::SEL_VECB);
		issue(2, ifd_pkg::OP_CTRLMV, 16'h1000);
		chk(dec_ctrl_sel, ifd_pkg::SEL_SRCFC);
		issue(2, ifd_pkg::OP_CTRLMV, 16'h1001);
		chk(dec_ctrl_sel, ifd_pkg::SEL_DSTFC);
		issue(2, ifd_pkg::OP_CTRLMV, 16'h1002);
		chk({dec_trap, dec_len}, 4'hA);
		issue(2, 16'h4C00, 16'h1405);
		chk({dec_class, dec_wide, dec_reg_a, dec_reg_b}, {ifd_pkg::CL_MULL, 7'h4D});
		issue(2, 16'h4C40, 16'h2406);
		chk({dec_class, dec_wide, dec_reg_a, dec_reg_b}, {ifd_pkg::CL_DIVL, 7'h56});
	endtask
	task automatic t_halt();
		int i;
		issue(3, ifd_pkg::OP_HALT, ifd_pkg::HALT_EXT, 16'h0400);
		chk(dec_len, 3'h3);
		repeat (4) @(posedge clock) #1;
		chk({halted, fetch_ready}, 2'h2);
		irq_level_pin = 3'h3;
		repeat (8) @(posedge clock) #1;
		chk(halted, 1'b1);
		irq_level_pin = 3'h4;
		for (i = 0; i < 3 && halted !== 1'b0; i++)
			@(posedge clock) #1;
		chk(halted, 1'b0);
		irq_level_pin = 3'h0;
	endtask
	// decode sets size and rounding, then one interpolation pulse
	task automatic t_tbl(input logic [15:0] ext, input logic [31:0] res,
		input logic [7:0] fo);
		int i;
		issue(2, ifd_pkg::OP_HALT, ext);
		chk(dec_trap, 1'b0);
		tbl_entry_lo = 32'h0000000A;
		tbl_entry_hi = 32'h00000014;
		tbl_frac = 8'h40;
		tbl_start = 1'b1;
		@(posedge clock) #1;
		tbl_start = 1'b0;
		for (i = 0; i < 3 && tbl_done !== 1'b1; i++)
			@(posedge clock) #1;
		chk({tbl_result, tbl_frac_out}, {res, fo});
	endtask
	initial
	begin
		tbl_start = 1'b0;
		tbl_entry_lo = 32'h0;
		tbl_entry_hi = 32'h0;
		tbl_frac = 8'h0;
		repeat (20) @(posedge clock);
		#1 rstn = 1'b1;
		chk({fetch_ready, dec_valid, halted}, 3'h4);
		t_format();
		t_cond();
		t_ctrl();
		t_halt();
		t_tbl(16'h0040, 32'h0000000D, 8'h00);
		t_tbl(16'h0440, 32'h0000000C, 8'h80);
		t_tbl(16'h0000, 32'h0000000D, 8'h00);
		issue(2, ifd_pkg::OP_HALT, 16'h0480);
		chk({dec_trap, dec_len}, 4'hA);
		print_verdict();
	end
endmodule // tb_top
`default_nettype wire
